//--- hw/core_debug_entry_control.sv
/*
 * Debug entry control: gates external debug inputs, sequences entry into
 * halted debug state on breakpoint, watchpoint or request, drives halted ack.
 * Assumes the core reports pipeline status on ref_clk; external pins are
 * synchronised here through two flops.
 */
// How it works
// - permit low blocks inputs, ack low
// - breakpointed instruction executes without state change
// - flushed breakpointed instruction never halts
// - entry starts at execute, ack two later
// - prefetch abort beats breakpoint
// - breakpoint beats trap instructions
// - interrupt beats breakpoint, refetch later
// - interrupts disabled internally, status word untouched
// - watchpoint lets next instruction finish
// - instruction in execute at watch halt suppressed
// - prefetch abort after watchpoint: exception first
// - watch halt pc five instructions ahead
// - data abort or irq: latch, enter, halt
// - debug request registered, beats interrupts
// - request stops issue, waits execute completion
// - request halts even in monitor mode
// - halted: memory idle, aborts, interrupts ignored
// - one clock, memory and debug enables
// - ack high in debug state until restart is requested
`timescale 1ns/10ps
module core_debug_entry_control
  import debug_entry_pkg::*;
(
  input wire logic ref_clk,
  input wire logic reset_n,
  input wire logic debug_permit_in,
  input wire logic ext_watch_hit_in,
  input wire logic ext_break_hit_in,
  input wire logic ext_halt_request_in,
  input wire logic int_halt_request,
  input wire logic int_break_hit,
  input wire logic int_watch_hit,
  input wire logic monitor_mode_cfg,
  input wire logic irq_request_n,
  input wire logic fast_irq_request_n,
  input wire logic mem_clock_enable,
  input wire logic debug_clock_enable,
  input wire logic restart_req,
  input wire pipe_status_t pipe_status,
  output logic halted_ack_out,
  output logic fetch_break_mark,
  output logic prefetch_debug_abort,
  output logic data_debug_abort,
  output logic core_step,
  output core_ctrl_t core_ctrl
);

  dbg_state_t state_reg, state_next;
  logic [1:0] permit_sync_reg, watch_sync_reg, break_sync_reg, halt_sync_reg;
  logic dbg_req_reg;
  logic [1:0] seq_cnt_reg;
  logic watch_latched_reg;
  logic watch_dp_wait_reg;
  logic bkpt_pending_reg;
  logic permit, watch_hit, break_hit, halt_hit, irq_pending, step_en;

  // shared state decodes; the control flops all look at the next state
  function automatic logic is_halted(input dbg_state_t st);
    return st == ST_HALTED;
  endfunction : is_halted

  function automatic logic irq_open(input dbg_state_t st);
    // interrupts stay live only while running or finishing exception entry
    return (st == ST_RUN) | (st == ST_EXC_WT);
  endfunction : irq_open

  function automatic logic issue_stopped(input dbg_state_t st);
    return (st == ST_REQ_DRAIN) | (st == ST_HALTED);
  endfunction : issue_stopped

  function automatic logic exec_blocked(input dbg_state_t st);
    return (st == ST_BKPT_SEQ) | (st == ST_HALTED);
  endfunction : exec_blocked

  // external pins are asynchronous to ref_clk: two flops each
  always_ff @(posedge ref_clk) begin
    if (!reset_n) begin
      permit_sync_reg <= 2'h0;
      watch_sync_reg <= 2'h0;
      break_sync_reg <= 2'h0;
      halt_sync_reg <= 2'h0;
    end else begin
      permit_sync_reg <= {permit_sync_reg[0], debug_permit_in};
      watch_sync_reg <= {watch_sync_reg[0], ext_watch_hit_in};
      break_sync_reg <= {break_sync_reg[0], ext_break_hit_in};
      halt_sync_reg <= {halt_sync_reg[0], ext_halt_request_in};
    end
  end

  assign permit = permit_sync_reg[1];
  assign watch_hit = permit & (watch_sync_reg[1] | int_watch_hit);
  assign break_hit = permit & (break_sync_reg[1] | int_break_hit);
  assign halt_hit = permit & (halt_sync_reg[1] | int_halt_request);
  assign irq_pending = ~irq_request_n | ~fast_irq_request_n;

  // normal running steps on the memory enable, halted on the debug enable
  assign step_en = (state_reg == ST_HALTED) ? debug_clock_enable : mem_clock_enable;

  // request registered before reaching the core; dropped with permit
  always_ff @(posedge ref_clk) begin
    if (!reset_n) begin
      dbg_req_reg <= 1'b0;
    end else if (!permit || state_reg == ST_HALTED) begin
      dbg_req_reg <= 1'b0;
    end else if (halt_hit) begin
      dbg_req_reg <= 1'b1;
    end
  end

  // monitor mode turns hits into aborts; requests are never turned
  always_ff @(posedge ref_clk) begin
    if (!reset_n) begin
      fetch_break_mark <= 1'b0;
      prefetch_debug_abort <= 1'b0;
      data_debug_abort <= 1'b0;
    end else begin
      // mark follows fetch sample; the breakpoint unit qualifies it with
      // the inverted fetch advance and halfword select, not address bit 1
      fetch_break_mark <= break_hit & ~monitor_mode_cfg;
      prefetch_debug_abort <= break_hit & monitor_mode_cfg;
      data_debug_abort <= watch_hit & monitor_mode_cfg;
    end
  end

  always_comb begin
    state_next = state_reg;
    unique case (state_reg)
      ST_RUN: begin
        if (dbg_req_reg) begin
          state_next = ST_REQ_DRAIN;
        end else if (watch_latched_reg && (pipe_status.data_abort || irq_pending)) begin
          state_next = ST_EXC_WT;
        end else if (watch_latched_reg && pipe_status.next_prefetch_abt) begin
          state_next = ST_EXC_WT;
        end else if (watch_latched_reg && !watch_dp_wait_reg) begin
          state_next = ST_HALTED;
        end else if (bkpt_pending_reg && pipe_status.exec_valid && !pipe_status.flush) begin
          // prefetch abort wins over breakpoint; breakpoint wins over traps
          if (!pipe_status.exec_prefetch_abt && !irq_pending) begin
            state_next = ST_BKPT_SEQ;
          end
        end
      end
      ST_BKPT_SEQ: begin
        if (seq_cnt_reg == BKPT_ACK_DELAY - 2'h1) begin
          state_next = ST_HALTED;
        end
      end
      ST_WATCH_WT: state_next = ST_HALTED;
      ST_EXC_WT: begin
        if (pipe_status.exc_entry_done) begin
          state_next = ST_HALTED;
        end
      end
      ST_REQ_DRAIN: begin
        if (pipe_status.exec_done) begin
          state_next = ST_HALTED;
        end
      end
      ST_HALTED: begin
        if (restart_req) begin
          state_next = ST_RUN;
        end
      end
      default: state_next = ST_RUN;
    endcase
    if (!permit) begin
      state_next = ST_RUN;
    end
  end

  always_ff @(posedge ref_clk) begin
    if (!reset_n) begin
      state_reg <= ST_RUN;
    end else if (step_en || !permit) begin
      state_reg <= state_next;
    end
  end

  always_ff @(posedge ref_clk) begin
    if (!reset_n) begin
      seq_cnt_reg <= 2'h0;
    end else if (step_en) begin
      seq_cnt_reg <= (state_reg == ST_BKPT_SEQ) ? seq_cnt_reg + 2'h1 : 2'h0;
    end
  end

  // breakpoint status travels with the fetched instruction until execute
  always_ff @(posedge ref_clk) begin
    if (!reset_n) begin
      bkpt_pending_reg <= 1'b0;
    end else if (step_en) begin
      if (pipe_status.flush) begin
        bkpt_pending_reg <= 1'b0;
      end else if (break_hit && !monitor_mode_cfg) begin
        bkpt_pending_reg <= 1'b1;
      end else if (pipe_status.exec_valid && pipe_status.exec_break_tag) begin
        bkpt_pending_reg <= 1'b0;
      end
    end
  end

  // watchpoint latched; the one cycle delay is fixed, a single-cycle dp op adds nothing
  always_ff @(posedge ref_clk) begin
    if (!reset_n) begin
      watch_latched_reg <= 1'b0;
      watch_dp_wait_reg <= 1'b0;
    end else if (!permit || state_reg == ST_HALTED) begin
      watch_latched_reg <= 1'b0;
      watch_dp_wait_reg <= 1'b0;
    end else if (step_en) begin
      if (watch_hit && !monitor_mode_cfg) begin
        watch_latched_reg <= 1'b1;
        watch_dp_wait_reg <= 1'b1;
      end else if (watch_dp_wait_reg) begin
        watch_dp_wait_reg <= pipe_status.exec_single_dp & ~watch_dp_wait_reg;
      end
    end
  end

  // halted ack only in debug state, forced low without permit
  always_ff @(posedge ref_clk) begin
    if (!reset_n) begin
      halted_ack_out <= DEBUG_STATE_RESET;
    end else begin
      halted_ack_out <= permit & (state_next == ST_HALTED) & (step_en | state_reg == ST_HALTED);
    end
  end

  always_ff @(posedge ref_clk) begin
    if (!reset_n) begin
      core_step <= 1'b0;
    end else begin
      core_step <= (state_next == ST_HALTED) ? debug_clock_enable : mem_clock_enable;
    end
  end

  // one flop per control, except mem_idle and abort_ignore which share idle_reg
  logic suppress_reg, hold_issue_reg, irq_block_reg, idle_reg, take_irq_reg;

  // breakpointed or post-watch instruction enters execute with no update
  always_ff @(posedge ref_clk) begin
    if (!reset_n) begin
      suppress_reg <= 1'b0;
    end else begin
      suppress_reg <= exec_blocked(state_next);
    end
  end

  always_ff @(posedge ref_clk) begin
    if (!reset_n) begin
      hold_issue_reg <= 1'b0;
    end else begin
      hold_issue_reg <= issue_stopped(state_next);
    end
  end

  // interrupt masking bits stay untouched; this gate is separate
  always_ff @(posedge ref_clk) begin
    if (!reset_n) begin
      irq_block_reg <= 1'b0;
    end else begin
      irq_block_reg <= ~irq_open(state_next);
    end
  end

  // memory idle and abort ignore share one flop: both mean halted
  always_ff @(posedge ref_clk) begin
    if (!reset_n) begin
      idle_reg <= 1'b0;
    end else begin
      idle_reg <= is_halted(state_next);
    end
  end

  always_ff @(posedge ref_clk) begin
    if (!reset_n) begin
      take_irq_reg <= 1'b0;
    end else begin
      take_irq_reg <= irq_pending & irq_open(state_next);
    end
  end

  assign core_ctrl = '{suppress_exec: suppress_reg, hold_issue: hold_issue_reg, irq_block: irq_block_reg,
                       mem_idle: idle_reg, abort_ignore: idle_reg, take_irq: take_irq_reg};

endmodule : core_debug_entry_control

//--- hw/debug_entry_pkg.sv
/*
 * Shared types and constants for the core debug entry control block.
 * Assumes one clock domain and a synchronous active-low reset.
 */
package debug_entry_pkg;

  // cycles from breakpointed instruction entering execute to halted ack
  localparam logic [1:0] BKPT_ACK_DELAY = 2'h2;
  // watchpoint halt pc is five instructions on; in full-width state that is 20 bytes
  localparam logic [31:0] WATCH_PC_REWIND = 32'h00000014;
  localparam logic DEBUG_STATE_RESET = 1'b0;

  // pipeline status reported by the core for the instruction in execute
  typedef struct packed {
    logic exec_valid;        // an instruction entered execute this step
    logic exec_break_tag;    // that instruction carried a breakpoint mark
    logic exec_prefetch_abt; // that instruction carried a prefetch abort
    logic exec_single_dp;    // single-cycle data processing op
    logic exec_done;         // execute instruction finished memory and write
    logic flush;             // pipeline flushed by a branch or exception
    logic data_abort;        // abort on the current data access
    logic exc_entry_done;    // exception entry sequence has completed
    logic next_prefetch_abt; // second instruction after watchpoint aborts
  } pipe_status_t;

  // debug controls returned to the core
  typedef struct packed {
    logic suppress_exec;   // block state update of instruction in execute
    logic hold_issue;      // issue nothing further into execute
    logic irq_block;       // interrupts disabled internally
    logic mem_idle;        // both memory interfaces signal internal cycles
    logic abort_ignore;    // aborts ignored while halted
    logic take_irq;        // take the interrupt now
  } core_ctrl_t;

  typedef enum logic [2:0] {
    ST_RUN       = 3'b000,
    ST_BKPT_SEQ  = 3'b001,
    ST_WATCH_WT  = 3'b010,
    ST_EXC_WT    = 3'b011,
    ST_REQ_DRAIN = 3'b100,
    ST_HALTED    = 3'b101
  } dbg_state_t;

endpackage : debug_entry_pkg

//--- test/debug_entry_props.sv
/* port assertions for the debug entry control block.
   assumes one clock and a synchronous active-low reset; bound to the top. */
`timescale 1ns/10ps
module debug_entry_props
  import debug_entry_pkg::*;
(
  input wire logic ref_clk,
  input wire logic reset_n,
  input wire logic debug_permit_in,
  input wire logic ext_halt_request_in,
  input wire logic monitor_mode_cfg,
  input wire logic restart_req,
  input wire pipe_status_t pipe_status,
  input wire logic halted_ack_out,
  input wire logic fetch_break_mark,
  input wire logic prefetch_debug_abort,
  input wire logic data_debug_abort,
  input wire core_ctrl_t core_ctrl
);
  default clocking @(posedge ref_clk); endclocking
  default disable iff (!reset_n);
  // four cycles lets the two sync flops and the ack flop settle
  property p_off_ack; !debug_permit_in [*4] |-> !halted_ack_out; endproperty
  a_off_ack: assert property (p_off_ack) else $error("ack high while debug blocked");
  property p_off_hits;
    !debug_permit_in [*4] |-> !(fetch_break_mark || prefetch_debug_abort || data_debug_abort);
  endproperty
  a_off_hits: assert property (p_off_hits) else $error("hit passed while debug blocked");
  property p_halt_idle; halted_ack_out |-> core_ctrl.mem_idle && core_ctrl.abort_ignore; endproperty
  a_halt_idle: assert property (p_halt_idle) else $error("memory not idle while halted");
  property p_halt_irq; halted_ack_out |-> core_ctrl.irq_block && !core_ctrl.take_irq; endproperty
  a_halt_irq: assert property (p_halt_irq) else $error("interrupts live while halted");
  property p_req_drain;
    debug_permit_in [*4] ##0 $rose(ext_halt_request_in) |-> ##[1:8] (core_ctrl.hold_issue || halted_ack_out);
  endproperty
  a_req_drain: assert property (p_req_drain) else $error("issue not stopped after request");
  property p_req_irq; core_ctrl.hold_issue |-> !core_ctrl.take_irq; endproperty
  a_req_irq: assert property (p_req_irq) else $error("interrupt taken during request drain");
  property p_mon_req;
    (monitor_mode_cfg && debug_permit_in && ext_halt_request_in && !restart_req && pipe_status.exec_done) [*8]
      |-> halted_ack_out;
  endproperty
  a_mon_req: assert property (p_mon_req) else $error("request did not halt in monitor mode");
  property p_ack_hold; (debug_permit_in && !restart_req) [*3] ##0 halted_ack_out |=> halted_ack_out; endproperty
  a_ack_hold: assert property (p_ack_hold) else $error("ack dropped while halted");
  c_halt: cover property ($rose(halted_ack_out));
  c_pabt: cover property (prefetch_debug_abort);
  c_dabt: cover property (data_debug_abort);
endmodule : debug_entry_props

bind core_debug_entry_control debug_entry_props i_props (.ref_clk(ref_clk), .reset_n(reset_n),
  .debug_permit_in(debug_permit_in), .ext_halt_request_in(ext_halt_request_in),
  .monitor_mode_cfg(monitor_mode_cfg), .restart_req(restart_req), .pipe_status(pipe_status),
  .halted_ack_out(halted_ack_out), .fetch_break_mark(fetch_break_mark),
  .prefetch_debug_abort(prefetch_debug_abort), .data_debug_abort(data_debug_abort), .core_ctrl(core_ctrl));

//--- test/far_side_model.sv
/* external comparators and system request logic facing the block.
   assumes the bench pulses go for one cycle with cmd: 1 break, 2 watch, 3 request. */
`timescale 1ns/10ps
module far_side_model (
  input wire logic ref_clk,
  input wire logic [1:0] cmd,
  input wire logic go,
  output logic break_hit,
  output logic watch_hit,
  output logic halt_req
);
  int cnt = 0;
  logic [1:0] cur = 2'h0;
  logic g;
  initial {break_hit, watch_hit, halt_req} = 3'h0;
  always @(posedge ref_clk) begin
    g = go;
    if (g) cur = cmd;
    #1;
    // matches last one cycle, requests held long enough to be registered
    if (g) cnt = (cur == 2'h3) ? 12 : 1;
    else if (cnt > 0) cnt = cnt - 1;
    break_hit = (cnt > 0) && (cur == 2'h1); // synchronous, with the fetch sample
    watch_hit = (cnt > 0) && (cur == 2'h2);
    halt_req = (cnt > 0) && (cur == 2'h3);
  end
endmodule : far_side_model

//--- test/core_debug_entry_control_tb.sv
/* self-checking bench for the debug entry control block.
   assumes the far side model drives the pins and the bench plays the core. */
`timescale 1ns/10ps
module core_debug_entry_control_tb
  import debug_entry_pkg::*;
;
  logic ref_clk = 1'b0, reset_n = 1'b0, permit = 1'b1, mon = 1'b0, irq_n = 1'b1;
  logic restart = 1'b0, go = 1'b0, pabt = 1'b0, flsh = 1'b0, brk_tag = 1'b0;
  logic [1:0] cmd = 2'h0;
  logic brk, wch, hreq, ack, mark, pab, dab, step;
  core_ctrl_t ctrl;
  pipe_status_t ps;
  int fails = 0, n_tests = 0;
  // valid, tag, prefetch abort, single dp, done, flush, data abort, entry done, next abort
  assign ps = {1'b1, brk_tag, pabt, 1'b0, 1'b1, flsh, 3'h2};
  initial forever #2 ref_clk = ~ref_clk;
  always @(posedge ref_clk) brk_tag <= mark;
  far_side_model i_far (.ref_clk(ref_clk), .cmd(cmd), .go(go), .break_hit(brk), .watch_hit(wch), .halt_req(hreq));
  core_debug_entry_control i_dut (.ref_clk(ref_clk), .reset_n(reset_n), .debug_permit_in(permit),
    .ext_watch_hit_in(wch), .ext_break_hit_in(brk), .ext_halt_request_in(hreq), .int_halt_request(1'b0),
    .int_break_hit(1'b0), .int_watch_hit(1'b0), .monitor_mode_cfg(mon), .irq_request_n(irq_n),
    .fast_irq_request_n(irq_n), .mem_clock_enable(1'b1), .debug_clock_enable(1'b1), .restart_req(restart),
    .pipe_status(ps), .halted_ack_out(ack), .fetch_break_mark(mark), .prefetch_debug_abort(pab),
    .data_debug_abort(dab), .core_step(step), .core_ctrl(ctrl));
  task automatic cyc(input int n);
    repeat (n) @(posedge ref_clk);
    #1;
  endtask : cyc
  task automatic check(input string what, input logic exp, input logic got);
    n_tests++;
    if (got !== exp) begin
      fails++;
      $display("CHECK FAILED %s expected %b seen %b", what, exp, got);
    end
  endtask : check
  task automatic run_case(input logic [1:0] c, input logic m, i, p, f, en, ack_exp, abt_exp);
    logic saw_ack, saw_abt;
    saw_ack = 1'b0;
    saw_abt = 1'b0;
    {mon, irq_n, pabt, flsh, permit} = {m, i, p, f, en};
    cmd = c;
    cyc(4);
    go = 1'b1;
    cyc(1);
    go = 1'b0;
    repeat (20) begin
      cyc(1);
      saw_ack = saw_ack | ack;
      saw_abt = saw_abt | pab | dab;
    end
    check("halted ack", ack_exp, saw_ack);
    check("debug abort", abt_exp, saw_abt);
    check("irq block while halted", ack_exp, ctrl.irq_block);
    check("memory idle while halted", ack_exp, ctrl.mem_idle);
    check("core step enable", 1'b1, step);
    {irq_n, pabt, flsh, permit} = 4'h9;
    restart = 1'b1;
    cyc(1);
    restart = 1'b0;
    cyc(8);
    check("ack after restart", 1'b0, ack);
  endtask : run_case
  task automatic final_report();
    $display("comparisons %0d mismatches %0d", n_tests, fails);
    if (fails == 0 && n_tests > 0) $display("All tests passed");
    else $display("Some tests failed");
    $finish;
  endtask : final_report
  initial begin
    cyc(5);
    reset_n = 1'b1; // held stable from here on, halted or not
    cyc(3);
    run_case(2'h1, 0, 1, 0, 0, 1, 1, 0);
    run_case(2'h2, 0, 1, 0, 0, 1, 1, 0);
    run_case(2'h3, 0, 1, 0, 0, 1, 1, 0);
    run_case(2'h3, 0, 0, 0, 0, 1, 1, 0);
    run_case(2'h3, 1, 1, 0, 0, 1, 1, 0);
    run_case(2'h1, 0, 0, 0, 0, 1, 0, 0);
    run_case(2'h2, 0, 0, 0, 0, 1, 1, 0);
    run_case(2'h1, 0, 1, 1, 0, 1, 0, 0);
    run_case(2'h1, 0, 1, 0, 1, 1, 0, 0);
    run_case(2'h1, 1, 1, 0, 0, 1, 0, 1);
    run_case(2'h2, 1, 1, 0, 0, 1, 0, 1);
    run_case(2'h3, 0, 1, 0, 0, 0, 0, 0);
    run_case(2'h1, 0, 1, 0, 0, 0, 0, 0);
    final_report();
  end
  initial begin
    #8000;
    fails++;
    final_report();
  end
endmodule : core_debug_entry_control_tb
